// [rtl/wkcfg_pkg.sv]
package wkcfg_pkg;

	// ************************************************************
	// frame layout
	// ************************************************************
	localparam logic [5:0] FRAME_BITS = 6'h20;
	localparam int ADDR_MSB = 31;
	localparam int ADDR_LSB = 25;
	localparam int RW_BIT = 24;
	localparam int FAULT_BIT = 23;
	localparam int IRQ_BIT = 22;
	localparam int DATA_MSB = 21;
	localparam int CMD_LSB = 24;
	localparam logic RW_WRITE = 1'h1;

	// ************************************************************
	// register map and reset values
	// ************************************************************
	localparam logic [6:0] ADDR_WAKE_PROG = 7'h10;
	localparam logic [6:0] ADDR_WAKE_GND = 7'h11;
	localparam logic [6:0] ADDR_COMP_PROG = 7'h12;
	localparam int PROG_CH = 8;
	localparam int GND_CH = 14;
	localparam int ALL_CH = 22;
	localparam logic [7:0] WAKE_PROG_RST = 8'hFF;
	localparam logic [13:0] WAKE_GND_RST = 14'h3FFF;
	localparam logic [7:0] COMP_PROG_RST = 8'h00;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_HZ = 20000000;
	localparam int POLL_PERIOD_MS = 64;
	localparam int POLL_PERIOD_CYC = POLL_PERIOD_MS * (CLK_HZ / 1000);
	localparam int POLL_ACTIVE_US = 64;
	localparam int POLL_ACTIVE_CYC = (POLL_ACTIVE_US * (CLK_HZ / 1000) + 999) / 1000;
	localparam int TIMER_W = 21;

	// ************************************************************
	// low-power sequencer states
	// ************************************************************
	typedef enum logic [1:0]
	{
		ST_RUN = 2'b00,
		ST_WAIT = 2'b01,
		ST_POLL = 2'b10
	} wkcfg_state_e;

	// register address compare, used by both write and read paths
	function automatic logic hitAddr(input logic [6:0] addr, input logic [6:0] reg_addr);
		hitAddr = (addr == reg_addr);
	endfunction

endpackage

// [rtl/wkcfg_sync.sv]
`timescale 1ns/10ps
module wkcfg_sync
	import wkcfg_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [WIDTH-1:0] asyncIn,
	input wire logic [WIDTH-1:0] resetVal,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// ************************************************************
	// two-stage synchroniser
	// ************************************************************
	// first stage feeds only the second; nothing else may look at it
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else if (ce)
		begin
			meta_ff <= asyncIn;
			sync_ff <= meta_ff;
		end
	end

	assign syncOut = sync_ff ^ resetVal;
endmodule

// [rtl/wkcfg_wake_ctrl.sv]
`timescale 1ns/10ps
module wkcfg_wake_ctrl
	import wkcfg_pkg::*;
#(
	parameter int POLL_CYC = POLL_PERIOD_CYC
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic sleepReq,
	input wire logic [ALL_CH-1:0] switchState,
	input wire logic [ALL_CH-1:0] wakeEnable,
	input wire logic [PROG_CH-1:0] compOnly,
	output logic lowPowerState_ff,
	output logic wakeEvent_ff,
	output logic pollTimerOn_ff,
	output logic [ALL_CH-1:0] currentEnable_ff
);
	wkcfg_state_e state_ff;
	logic sleepReqPrev_ff;
	logic [TIMER_W-1:0] timer_ff;
	logic [ALL_CH-1:0] refState_ff;
	logic [ALL_CH-1:0] compMask;
	logic [ALL_CH-1:0] changed;
	logic timerRun;
	logic compWake;
	logic pollWake;

	// comparator-only inputs are watched every cycle, the rest only when polled
	assign compMask = {{GND_CH{1'b0}}, compOnly};
	assign changed = (switchState ^ refState_ff) & wakeEnable;
	assign timerRun = |wakeEnable;
	assign compWake = |(changed & compMask);
	assign pollWake = |changed;

	// ************************************************************
	// low-power sequencer
	// ************************************************************
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_ff <= ST_RUN;
			sleepReqPrev_ff <= 1'b0;
			timer_ff <= '0;
			refState_ff <= '0;
			lowPowerState_ff <= 1'b0;
			wakeEvent_ff <= 1'b0;
			pollTimerOn_ff <= 1'b0;
			currentEnable_ff <= '0;
		end
		else if (ce)
		begin
			sleepReqPrev_ff <= sleepReq;
			wakeEvent_ff <= 1'b0;
			case (state_ff)
				ST_RUN:
				begin
					// entry on the rising edge so a held request cannot re-sleep at once
					if (sleepReq && !sleepReqPrev_ff)
					begin
						refState_ff <= switchState;
						timer_ff <= '0;
						lowPowerState_ff <= 1'b1;
						pollTimerOn_ff <= timerRun;
						state_ff <= ST_WAIT;
					end
				end
				ST_WAIT:
				begin
					pollTimerOn_ff <= timerRun;
					if (compWake)
					begin
						lowPowerState_ff <= 1'b0;
						wakeEvent_ff <= 1'b1;
						pollTimerOn_ff <= 1'b0;
						state_ff <= ST_RUN;
					end
					else if (!timerRun)
						timer_ff <= '0;
					else if (timer_ff == TIMER_W'(POLL_CYC - 1))
					begin
						timer_ff <= '0;
						currentEnable_ff <= ~compMask;
						state_ff <= ST_POLL;
					end
					else
						timer_ff <= timer_ff + 1'b1;
				end
				ST_POLL:
				begin
					// states are judged at the end of the current pulse, when inputs settled
					if (compWake || timer_ff == TIMER_W'(POLL_ACTIVE_CYC - 1))
					begin
						timer_ff <= '0;
						currentEnable_ff <= '0;
						if (pollWake)
						begin
							lowPowerState_ff <= 1'b0;
							wakeEvent_ff <= 1'b1;
							pollTimerOn_ff <= 1'b0;
							state_ff <= ST_RUN;
						end
						else
							state_ff <= ST_WAIT;
					end
					else
						timer_ff <= timer_ff + 1'b1;
				end
				default:
				begin
					state_ff <= ST_RUN;
					lowPowerState_ff <= 1'b0;
				end
			endcase
		end
	end
endmodule

// [rtl/wkcfg_regs.sv]
// What this block does
// - address 0x10 (bits 31..25, bit 24 read/write) is the programmable-channel wake enable, data 7..0.
// - address 0x11 is the ground-switch wake enable, data 13..0, bits 23..14 unused.
// - a channel whose wake bit is 0 never ends the low-power state by its own change.
// - a channel whose wake bit is 1 ends the low-power state on any detected change.
// - the host may rewrite either wake register at any time and the write takes effect.
// - after reset all 8 plus 14 wake bits are 1 and unused bits are 0.
// - when every wake bit is 0 the polling timer stops.
// - comparator-only programmable channels keep watching in low power with no polling current.
// - comparator-only channels follow a driven input continuously and wake on a change when their wake bit is 1.
// - address 0x12 is the programmable comparator-only register, data 7..0, reset 0.
// - each returned word carries fault in bit 23, pending interrupt in bit 22, data in 21..0.
// - the polling timer sets the spacing of polls that briefly turn on channel currents.
`timescale 1ns/10ps
module wkcfg_regs
	import wkcfg_pkg::*;
#(
	parameter int POLL_CYC = POLL_PERIOD_CYC
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic serialClk,
	input wire logic chipSelN,
	input wire logic serialIn,
	output logic serialOut,
	output logic serialOutEn,
	input wire logic faultSummary,
	input wire logic pendingIrqBit,
	input wire logic sleepReq,
	input wire logic [ALL_CH-1:0] switchPin,
	output logic lowPowerState,
	output logic wakeEvent,
	output logic pollTimerOn,
	output logic [ALL_CH-1:0] currentEnable
);
	// ************************************************************
	// declarations
	// ************************************************************
	logic [2:0] pinSync;
	logic sclkS;
	logic csNS;
	logic mosiS;
	logic [ALL_CH-1:0] switchS;
	logic sclkPrev_ff;
	logic csNPrev_ff;
	logic [31:0] rxShift_ff;
	logic [5:0] bitCount_ff;
	logic [31:0] txShift_ff;
	logic serialOut_ff;
	logic serialOutEn_ff;
	logic frameDone_ff;
	logic readNow_ff;
	logic [31:0] frameWord_ff;
	logic [7:0] lastCmd_ff;
	logic [DATA_MSB:0] readBack_ff;
	logic [7:0] wakeProg_ff;
	logic [13:0] wakeGnd_ff;
	logic [7:0] compProg_ff;
	logic sclkRise;
	logic sclkFall;
	logic csFall;
	logic csRise;
	logic [6:0] frameAddr;
	logic frameWrite;
	logic [23:0] frameData;
	logic [DATA_MSB:0] nxt_readBack;
	logic [31:0] nxt_txWord;

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	// chip select idles high, so its synchroniser is reset to the idle level
	wkcfg_sync #(.WIDTH(3)) u_pinSync
	(
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.asyncIn({serialClk, ~chipSelN, serialIn}),
		.resetVal(3'h2),
		.syncOut(pinSync)
	);

	assign sclkS = pinSync[2];
	assign csNS = pinSync[1];
	assign mosiS = pinSync[0];

	// switch comparator outputs come from the analog side, asynchronous to clk
	wkcfg_sync #(.WIDTH(ALL_CH)) u_swSync
	(
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.asyncIn(switchPin),
		.resetVal({ALL_CH{1'b0}}),
		.syncOut(switchS)
	);

	// ************************************************************
	// link edge detection
	// ************************************************************
	// the link clock is slow (8 clk per period), so sampled edges are safe
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sclkPrev_ff <= 1'b0;
			csNPrev_ff <= 1'b1;
		end
		else if (ce)
		begin
			sclkPrev_ff <= sclkS;
			csNPrev_ff <= csNS;
		end
	end

	assign sclkRise = sclkS && !sclkPrev_ff && !csNS;
	assign sclkFall = !sclkS && sclkPrev_ff && !csNS;
	assign csFall = !csNS && csNPrev_ff;
	assign csRise = csNS && !csNPrev_ff;

	// ************************************************************
	// receive shifter
	// ************************************************************
	// data is taken on the rising link clock edge, msb first
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rxShift_ff <= '0;
			bitCount_ff <= '0;
		end
		else if (ce)
		begin
			if (csFall)
				bitCount_ff <= '0;
			else if (sclkRise)
			begin
				rxShift_ff <= {rxShift_ff[30:0], mosiS};
				// saturate so an overlong frame is not mistaken for a good one
				if (bitCount_ff != 6'h3F)
					bitCount_ff <= bitCount_ff + 1'b1;
			end
		end
	end

	// ************************************************************
	// frame completion
	// ************************************************************
	// only a frame of exactly 32 bits is acted on; others are dropped silently
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			frameDone_ff <= 1'b0;
			readNow_ff <= 1'b0;
			frameWord_ff <= '0;
		end
		else if (ce)
		begin
			frameDone_ff <= csRise && (bitCount_ff == FRAME_BITS);
			// read-back waits one cycle so a write of the same frame has landed
			readNow_ff <= frameDone_ff;
			if (csRise)
				frameWord_ff <= rxShift_ff;
		end
	end

	assign frameAddr = frameWord_ff[ADDR_MSB:ADDR_LSB];
	assign frameWrite = (frameWord_ff[RW_BIT] == RW_WRITE);
	assign frameData = frameWord_ff[23:0];

	// ************************************************************
	// wake enable registers
	// ************************************************************
	// writes are taken in any mode, so software updates apply at once
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wakeProg_ff <= WAKE_PROG_RST;
			wakeGnd_ff <= WAKE_GND_RST;
		end
		else if (ce && frameDone_ff && frameWrite)
		begin
			if (hitAddr(frameAddr, ADDR_WAKE_PROG))
				wakeProg_ff <= frameData[PROG_CH-1:0];
			if (hitAddr(frameAddr, ADDR_WAKE_GND))
				wakeGnd_ff <= frameData[GND_CH-1:0];
		end
	end

	// ************************************************************
	// comparator-only register
	// ************************************************************
	always_ff @(posedge clk)
	begin
		if (reset)
			compProg_ff <= COMP_PROG_RST;
		else if (ce && frameDone_ff && frameWrite && hitAddr(frameAddr, ADDR_COMP_PROG))
			compProg_ff <= frameData[PROG_CH-1:0];
	end

	// ************************************************************
	// read-back selection
	// ************************************************************
	// value after any write of the same frame; unmapped addresses read zero
	always_comb
	begin
		nxt_readBack = '0;
		if (hitAddr(frameAddr, ADDR_WAKE_PROG))
			nxt_readBack = {14'h0000, wakeProg_ff};
		else if (hitAddr(frameAddr, ADDR_WAKE_GND))
			nxt_readBack = {8'h00, wakeGnd_ff};
		else if (hitAddr(frameAddr, ADDR_COMP_PROG))
			nxt_readBack = {14'h0000, compProg_ff};
	end

	// captured one cycle after the write so it shows the new contents
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			readBack_ff <= '0;
			lastCmd_ff <= '0;
		end
		else if (ce && readNow_ff)
		begin
			readBack_ff <= nxt_readBack;
			lastCmd_ff <= frameWord_ff[31:CMD_LSB];
		end
	end

	// ************************************************************
	// transmit shifter
	// ************************************************************
	// reply belongs to the previous frame; status flags are live at frame start
	assign nxt_txWord = {lastCmd_ff, faultSummary, pendingIrqBit, readBack_ff};

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			txShift_ff <= '0;
			serialOut_ff <= 1'b0;
			serialOutEn_ff <= 1'b0;
		end
		else if (ce)
		begin
			serialOutEn_ff <= !csNS;
			if (csFall)
			begin
				txShift_ff <= {nxt_txWord[30:0], 1'b0};
				serialOut_ff <= nxt_txWord[31];
			end
			else if (sclkFall)
			begin
				// the host samples on the rising edge, so change on the falling one
				serialOut_ff <= txShift_ff[31];
				txShift_ff <= {txShift_ff[30:0], 1'b0};
			end
		end
	end

	assign serialOut = serialOut_ff;
	assign serialOutEn = serialOutEn_ff;

	// ************************************************************
	// low-power wake control
	// ************************************************************
	wkcfg_wake_ctrl #(.POLL_CYC(POLL_CYC)) u_wake
	(
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.sleepReq(sleepReq),
		.switchState(switchS),
		.wakeEnable({wakeGnd_ff, wakeProg_ff}),
		.compOnly(compProg_ff),
		.lowPowerState_ff(lowPowerState),
		.wakeEvent_ff(wakeEvent),
		.pollTimerOn_ff(pollTimerOn),
		.currentEnable_ff(currentEnable)
	);
endmodule

// [sim/wkcfg_regs_properties.sv]
`timescale 1ns/10ps
module wkcfg_regs_properties
	import wkcfg_pkg::*;
#(
	parameter int POLL_CYC = POLL_PERIOD_CYC
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic chipSelN,
	input wire logic serialOutEn,
	input wire logic lowPowerState,
	input wire logic wakeEvent,
	input wire logic pollTimerOn,
	input wire logic [ALL_CH-1:0] currentEnable
);
	// ****************
	// checks
	// ****************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic curOn;
	logic [10:0] onCnt_ff;
	assign curOn = |currentEnable;
	// length of the current poll pulse so far
	always_ff @(posedge clk)
	begin
		if (reset || !curOn)
			onCnt_ff <= 11'h000;
		else
			onCnt_ff <= onCnt_ff + 11'h001;
	end
	// a wake may cut a pulse short, so only pulses ending in low power count
	a_poll_pulse_len: assert property ($fell(curOn) && lowPowerState |-> int'(onCnt_ff) == POLL_ACTIVE_CYC)
		else $error("poll pulse has wrong length");
	a_current_needs_timer: assert property (curOn |-> pollTimerOn)
		else $error("current on without polling timer");
	a_timer_in_lp: assert property (pollTimerOn |-> lowPowerState)
		else $error("polling timer outside low power");
	a_wake_single: assert property (wakeEvent |=> !wakeEvent)
		else $error("wake pulse longer than one cycle");
	a_wake_from_lp: assert property ($rose(wakeEvent) |-> $past(lowPowerState))
		else $error("wake while not in low power");
	a_wake_ends_lp: assert property (wakeEvent |-> ##[0:1] !lowPowerState)
		else $error("wake did not end low power");
	a_lp_exit_cause: assert property ($fell(lowPowerState) |-> (wakeEvent || $past(wakeEvent)) or ##1 wakeEvent)
		else $error("low power left without wake");
	a_reply_drive_on: assert property ($fell(chipSelN) |-> ##[1:5] serialOutEn)
		else $error("reply line not driven in frame");
	a_reply_drive_off: assert property ($rose(chipSelN) |-> ##[1:5] !serialOutEn)
		else $error("reply line driven after frame");
endmodule

bind wkcfg_regs wkcfg_regs_properties #(.POLL_CYC(POLL_CYC)) u_wkcfg_regs_properties (.clk(clk),
	.reset(reset), .chipSelN(chipSelN), .serialOutEn(serialOutEn), .lowPowerState(lowPowerState),
	.wakeEvent(wakeEvent), .pollTimerOn(pollTimerOn), .currentEnable(currentEnable));

// [sim/wkcfg_host.sv]
`timescale 1ns/10ps
module wkcfg_host
(
	input wire logic clk,
	input wire logic serialOut,
	output logic serialClk,
	output logic chipSelN,
	output logic serialIn
);
	// ****************
	// link master
	// ****************
	initial
	begin
		serialClk = 1'b0;
		chipSelN = 1'b1;
		serialIn = 1'b0;
	end
	// n bits msb first, idle clock low; any frame may come at any time in normal mode
	task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
		rx = 32'h0;
		@(posedge clk);
		#1 chipSelN = 1'b0;
		for (int i = 31; i > 31 - n; i--)
		begin
			repeat (4) @(posedge clk);
			#1 serialClk = 1'b0;
			serialIn = tx[i];
			repeat (4) @(posedge clk);
			#1 serialClk = 1'b1;
			rx[i] = serialOut;
		end
		repeat (4) @(posedge clk);
		#1 serialClk = 1'b0;
		repeat (4) @(posedge clk);
		#1 chipSelN = 1'b1;
		serialIn = ~serialIn; // released line must not look like the last bit
		repeat (8) @(posedge clk);
	endtask
endmodule

// [sim/wkcfg_regs_tb.sv]
`timescale 1ns/10ps
module wkcfg_regs_tb
	import wkcfg_pkg::*;
;
	// ****************
	// bench
	// ****************
	localparam int POLL_SIM = 50; // short poll spacing keeps the run brief
	logic clk, reset, ce, serialClk, chipSelN, serialIn, serialOut, serialOutEn;
	logic faultSummary, pendingIrqBit, sleepReq, lowPowerState, wakeEvent, pollTimerOn;
	logic [ALL_CH-1:0] switchPin, currentEnable;
	logic [31:0] rx;
	int badCount, nTests, cycles;
	wkcfg_regs #(.POLL_CYC(POLL_SIM)) u_wkcfg_regs (.clk(clk), .reset(reset), .ce(ce),
		.serialClk(serialClk), .chipSelN(chipSelN), .serialIn(serialIn), .serialOut(serialOut),
		.serialOutEn(serialOutEn), .faultSummary(faultSummary), .pendingIrqBit(pendingIrqBit),
		.sleepReq(sleepReq), .switchPin(switchPin), .lowPowerState(lowPowerState),
		.wakeEvent(wakeEvent), .pollTimerOn(pollTimerOn), .currentEnable(currentEnable));
	wkcfg_host u_wkcfg_host (.clk(clk), .serialOut(serialOut), .serialClk(serialClk),
		.chipSelN(chipSelN), .serialIn(serialIn));
	initial
		clk = 1'b0;
	always #25 clk = ~clk;
	// hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 50000)
		begin
			badCount++;
			stopTest();
		end
	end
	task automatic stopTest();
		$display("checks %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp)
		begin
			badCount++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [6:0] addr, input logic [23:0] data);
		u_wkcfg_host.xfer({addr, RW_WRITE, data}, 32, rx);
	endtask
	// the reply comes one frame late, so a read takes two frames
	task automatic rd(input logic [6:0] addr, input logic [21:0] exp);
		u_wkcfg_host.xfer({addr, 1'b0, 24'h0}, 32, rx);
		u_wkcfg_host.xfer({addr, 1'b0, 24'h0}, 32, rx);
		chk("reply data", {10'h0, rx[21:0]}, {10'h0, exp});
		chk("reply command", {24'h0, rx[31:24]}, {24'h0, addr, 1'b0});
		chk("reply flags", {30'h0, rx[23:22]}, {30'h0, faultSummary, pendingIrqBit});
	endtask
	// sel 0 waits for poll currents, 1 for their end, 2 for a wake pulse
	task automatic waitSig(input int sel, input int lim);
		for (int k = 0; k < lim; k++)
		begin
			if ((sel == 0 && currentEnable !== 22'h0) || (sel == 1 && currentEnable === 22'h0)
				|| (sel == 2 && wakeEvent === 1'b1))
				return;
			tick(1);
		end
		chk("wait timeout", 32'h0, 32'h1);
	endtask
	initial
	begin
		ce = 1'b1;
		reset = 1'b1;
		faultSummary = 1'b1;
		pendingIrqBit = 1'b0;
		sleepReq = 1'b0;
		switchPin = 22'h0;
		tick(12);
		reset = 1'b0;
		tick(2);
		rd(ADDR_WAKE_PROG, 22'h0000FF);
		rd(ADDR_WAKE_GND, 22'h003FFF);
		faultSummary = 1'b0;
		pendingIrqBit = 1'b1;
		rd(ADDR_COMP_PROG, 22'h000000);
		$display("test reset_values done");
		wr(ADDR_WAKE_PROG, 24'hFFFF5A);
		wr(ADDR_WAKE_GND, 24'hFFC0A5);
		wr(ADDR_COMP_PROG, 24'hFFFF3C);
		// this frame's reply shows the ground-switch register after its write
		chk("reply after write", {10'h0, rx[21:0]}, 32'h000000A5);
		wr(7'h13, 24'hFFFFFF);
		rd(ADDR_WAKE_PROG, 22'h00005A);
		rd(ADDR_WAKE_GND, 22'h0000A5);
		rd(ADDR_COMP_PROG, 22'h00003C);
		rd(7'h13, 22'h000000);
		// a 31 bit frame must write nothing
		u_wkcfg_host.xfer({ADDR_WAKE_PROG, RW_WRITE, 24'h000000}, 31, rx);
		rd(ADDR_WAKE_PROG, 22'h00005A);
		$display("test write_read done");
		wr(ADDR_WAKE_PROG, 24'h000001);
		wr(ADDR_WAKE_GND, 24'h000000);
		wr(ADDR_COMP_PROG, 24'h000000);
		sleepReq = 1'b1;
		tick(2);
		chk("low power and timer", 32'({lowPowerState, pollTimerOn}), 32'h3);
		waitSig(0, 200);
		chk("poll currents", 32'(currentEnable), 32'h3FFFFF);
		waitSig(1, 1400);
		switchPin[1] = 1'b1;
		waitSig(0, 200);
		waitSig(1, 1400);
		tick(2);
		chk("disabled channel kept low power", 32'(lowPowerState), 32'h1);
		switchPin[0] = 1'b1;
		waitSig(2, 3000);
		tick(1);
		chk("enabled channel woke", 32'(lowPowerState), 32'h0);
		sleepReq = 1'b0;
		$display("test polled_wake done");
		wr(ADDR_COMP_PROG, 24'h000004);
		wr(ADDR_WAKE_PROG, 24'h000004);
		sleepReq = 1'b1;
		waitSig(0, 200);
		chk("comparator-only current off", 32'(currentEnable), 32'h3FFFFB);
		waitSig(1, 1400);
		switchPin[2] = 1'b1;
		waitSig(2, 8);
		sleepReq = 1'b0;
		$display("test comparator_wake done");
		wr(ADDR_WAKE_PROG, 24'h000000);
		sleepReq = 1'b1;
		tick(2);
		switchPin = 22'h0;
		tick(200);
		chk("no timer no polls no wake", 32'({lowPowerState, pollTimerOn, currentEnable}),
			32'h800000);
		$display("test all_disabled done");
		stopTest();
	end
endmodule
